// File: hw/sli_params.svh
// timing and encoding constants for the status indicator encoder
`ifndef SLI_PARAMS_SVH
`define SLI_PARAMS_SVH
`define SLI_CLK_HZ 100000000
`define SLI_TICK_HZ 8
`define SLI_TICK_CYCLES (`SLI_CLK_HZ / `SLI_TICK_HZ)
`define SLI_HALF_FAST 2
`define SLI_HALF_SLOW 8
`define SLI_ADDR_CTRL 32'h0000_0000
`define SLI_ADDR_OPT 32'h0000_0004
`define SLI_ADDR_STAT 32'h0000_0008
`define SLI_LED_OFF 2'h0
`define SLI_LED_GREEN 2'h1
`define SLI_LED_RED 2'h2
`define SLI_LED_ORANGE 2'h3
`endif

// File: hw/sli_pkg.sv
// types shared by the status indicator encoder
package sli_pkg;
	typedef enum logic [1:0] {
		SLI_OFF = 2'h0,
		SLI_GREEN = 2'h1,
		SLI_RED = 2'h2,
		SLI_ORANGE = 2'h3
	} sli_colour_t;
	typedef enum logic [2:0] {
		SLI_STEADY = 3'h1,
		SLI_SLOW = 3'h2,
		SLI_FAST = 3'h4
	} sli_pattern_t;
endpackage

// File: hw/sli_timebase.sv
// shared flash time base: 2 Hz and 0.5 Hz phases from one divider
`timescale 1ns/10ps
`default_nettype none
`include "sli_params.svh"
module sli_timebase #(
	parameter int TICK_CYCLES = `SLI_TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic resetn,
	output logic fastPhase,
	output logic slowPhase
);
	logic [31:0] divReg;
	logic [3:0] tickReg;
	logic tick;
	assign tick = (divReg == 32'(TICK_CYCLES - 1));
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			divReg <= 32'h0;
		end else if (tick) begin
			divReg <= 32'h0;
		end else begin
			divReg <= divReg + 32'h1;
		end
	end
	// one counter feeds both rates, so flashes stay in phase
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tickReg <= 4'h0;
		end else if (tick) begin
			tickReg <= tickReg + 4'h1;
		end
	end
	assign fastPhase = ~tickReg[1];
	assign slowPhase = ~tickReg[3];
endmodule
`default_nettype wire

// File: hw/sli_ahb_slave.sv
// AHB-Lite register slave holding status inputs and a read-back word
`timescale 1ns/10ps
`default_nettype none
`include "sli_params.svh"
module sli_ahb_slave (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [15:0] ctrlReg,
	output logic [7:0] optReg,
	input wire logic [31:0] statIn
);
	logic wrPend;
	logic [31:0] addrReg;
	logic take;
	logic [15:0] ctrlNow;
	logic [7:0] optNow;
	assign take = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wrPend <= 1'b0;
			addrReg <= 32'h0;
		end else begin
			wrPend <= take && hwrite;
			if (take) begin
				addrReg <= haddr;
			end
		end
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctrlReg <= 16'h0;
			optReg <= 8'h0;
		end else if (wrPend) begin
			if (addrReg == `SLI_ADDR_CTRL) begin
				ctrlReg <= hwdata[15:0];
			end
			if (addrReg == `SLI_ADDR_OPT) begin
				optReg <= hwdata[7:0];
			end
		end
	end
	// a write still in its data phase is forwarded, so a read right behind
	// it sees the new word rather than a stale one
	assign ctrlNow = (wrPend && addrReg == `SLI_ADDR_CTRL) ? hwdata[15:0]
		: ctrlReg;
	assign optNow = (wrPend && addrReg == `SLI_ADDR_OPT) ? hwdata[7:0]
		: optReg;
	// read data registered at the address phase; unmapped reads zero
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hrdata <= 32'h0;
		end else if (take && !hwrite) begin
			if (haddr == `SLI_ADDR_CTRL) begin
				hrdata <= {16'h0, ctrlNow};
			end else if (haddr == `SLI_ADDR_OPT) begin
				hrdata <= {24'h0, optNow};
			end else if (haddr == `SLI_ADDR_STAT) begin
				hrdata <= statIn;
			end else begin
				hrdata <= 32'h0;
			end
		end
	end
endmodule
`default_nettype wire

// File: hw/sli_led_encoder.sv
// front-panel status indicator encoder with AHB-Lite status registers
// Summary of operation
// - fieldbus steady green while cyclic communication runs normally
// - fieldbus green 0.5 Hz when data exchange exists but not full operation
// - fieldbus steady red when legacy serial selected and bus idle
// - fieldbus red 0.5 Hz when legacy serial active without process data
// - fieldbus red 2 Hz on config fault, lost exchange, baud search, no link
// - option dark when board absent or no drive object
// - option steady green when board ready
// - option green 0.5 Hz for board-specific condition
// - option red 2 Hz on option fault or board not yet ready
// - unit and fieldbus red 2 Hz when bus communication interrupted
// - unit and option orange 0.5 Hz during Ethernet board firmware update
// - fieldbus dark until first cyclic communication unless a fault or legacy serial is flagged
// - unit steady green when ready and error free
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "sli_params.svh"
module sli_led_encoder
	import sli_pkg::*;
#(
	parameter int TICK_CYCLES = `SLI_TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [1:0] unitLed,
	output logic [1:0] fieldbusLed,
	output logic [1:0] optionLed,
	output logic [1:0] spareLed
);
	logic [15:0] ctrlReg;
	logic [7:0] optReg;
	logic fastPhase;
	logic slowPhase;
	logic cyclicOk, dataExchange, serialSel, serialActive, procDataRx;
	logic cfgFault, lostExchange, baudSearch, noLink, commInterrupt;
	logic unitReady, unitError, fwUpdate;
	logic optPresent, optReady, optObject, optSpecial, optFault;
	logic seenCyclic_reg;
	logic [1:0] unitNext, fbNext, optNext;
	logic [31:0] statWord;
	// control bits written by firmware
	assign cyclicOk = ctrlReg[0];
	assign dataExchange = ctrlReg[1];
	assign serialSel = ctrlReg[2];
	assign serialActive = ctrlReg[3];
	assign procDataRx = ctrlReg[4];
	assign cfgFault = ctrlReg[5];
	assign lostExchange = ctrlReg[6];
	assign baudSearch = ctrlReg[7];
	assign noLink = ctrlReg[8];
	assign commInterrupt = ctrlReg[9];
	assign unitReady = ctrlReg[10];
	assign unitError = ctrlReg[11];
	assign fwUpdate = ctrlReg[12];
	assign optPresent = optReg[0];
	assign optReady = optReg[1];
	assign optObject = optReg[2];
	assign optSpecial = optReg[3];
	assign optFault = optReg[4];
	assign statWord = {21'h0, fastPhase, slowPhase, seenCyclic_reg,
		spareLed, optionLed, fieldbusLed, unitLed};

	sli_ahb_slave bus (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.ctrlReg(ctrlReg),
		.optReg(optReg),
		.statIn(statWord)
	);

	sli_timebase #(.TICK_CYCLES(TICK_CYCLES)) tb (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.fastPhase(fastPhase),
		.slowPhase(slowPhase)
	);

	// sticky: once cyclic traffic has happened the fieldbus LED may light
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			seenCyclic_reg <= 1'b0;
		end else if (cyclicOk) begin
			seenCyclic_reg <= 1'b1;
		end
	end

	// unit indicator; bus interruption outranks firmware update
	always_comb begin
		unitNext = `SLI_LED_OFF;
		if (commInterrupt) begin
			unitNext = fastPhase ? `SLI_LED_RED : `SLI_LED_OFF;
		end else if (fwUpdate) begin
			unitNext = slowPhase ? `SLI_LED_ORANGE : `SLI_LED_OFF;
		end else if (unitReady && !unitError) begin
			unitNext = `SLI_LED_GREEN;
		end
	end

	// fieldbus indicator; faults first, then legacy serial, then healthy
	always_comb begin
		fbNext = `SLI_LED_OFF;
		if (commInterrupt) begin
			fbNext = fastPhase ? `SLI_LED_RED : `SLI_LED_OFF;
		end else if (cfgFault || lostExchange || baudSearch || noLink) begin
			fbNext = fastPhase ? `SLI_LED_RED : `SLI_LED_OFF;
		end else if (serialSel && !serialActive) begin
			fbNext = `SLI_LED_RED;
		end else if (serialSel && !procDataRx) begin
			fbNext = slowPhase ? `SLI_LED_RED : `SLI_LED_OFF;
		end else if (!seenCyclic_reg && !cyclicOk) begin
			fbNext = `SLI_LED_OFF;
		end else if (cyclicOk) begin
			fbNext = `SLI_LED_GREEN;
		end else if (dataExchange) begin
			fbNext = slowPhase ? `SLI_LED_GREEN : `SLI_LED_OFF;
		end
	end

	// option-slot indicator
	always_comb begin
		optNext = `SLI_LED_OFF;
		if (fwUpdate) begin
			optNext = slowPhase ? `SLI_LED_ORANGE : `SLI_LED_OFF;
		end else if (!optPresent || !optObject) begin
			optNext = `SLI_LED_OFF;
		end else if (optFault || !optReady) begin
			optNext = fastPhase ? `SLI_LED_RED : `SLI_LED_OFF;
		end else if (optSpecial) begin
			optNext = slowPhase ? `SLI_LED_GREEN : `SLI_LED_OFF;
		end else begin
			optNext = `SLI_LED_GREEN;
		end
	end

	// outputs registered so the pins never glitch
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			unitLed <= `SLI_LED_OFF;
			fieldbusLed <= `SLI_LED_OFF;
			optionLed <= `SLI_LED_OFF;
			spareLed <= `SLI_LED_OFF;
		end else begin
			unitLed <= unitNext;
			fieldbusLed <= fbNext;
			optionLed <= optNext;
			spareLed <= `SLI_LED_OFF;
		end
	end

	a_spare_dark: assert property (@(posedge sys_clk) disable iff (!resetn)
		spareLed == `SLI_LED_OFF) else $error("spare lit");
	a_fb_green: assert property (@(posedge sys_clk) disable iff (!resetn)
		(cyclicOk && !commInterrupt && !cfgFault && !lostExchange
		&& !baudSearch && !noLink && !serialSel) |=> fieldbusLed
		== `SLI_LED_GREEN) else $error("fieldbus not green");
	a_fb_dark_first: assert property (@(posedge sys_clk)
		disable iff (!resetn) (!seenCyclic_reg && !cyclicOk && !commInterrupt
		&& !cfgFault && !lostExchange && !baudSearch && !noLink && !serialSel)
		|=> fieldbusLed == `SLI_LED_OFF) else $error("fieldbus early");
	a_fb_serial_red: assert property (@(posedge sys_clk)
		disable iff (!resetn) (serialSel && !serialActive && !commInterrupt
		&& !cfgFault && !lostExchange && !baudSearch && !noLink)
		|=> fieldbusLed == `SLI_LED_RED) else $error("serial red");
	a_fb_fault_flash: assert property (@(posedge sys_clk)
		disable iff (!resetn) (noLink && !commInterrupt)
		|=> fieldbusLed == ($past(fastPhase) ? `SLI_LED_RED : `SLI_LED_OFF))
		else $error("fault flash");
	a_unit_green: assert property (@(posedge sys_clk) disable iff (!resetn)
		(unitReady && !unitError && !commInterrupt && !fwUpdate)
		|=> unitLed == `SLI_LED_GREEN) else $error("unit not green");
	a_intr_phase: assert property (@(posedge sys_clk) disable iff (!resetn)
		commInterrupt |=> unitLed == fieldbusLed) else $error("phase");
	a_fw_orange: assert property (@(posedge sys_clk) disable iff (!resetn)
		(fwUpdate && !commInterrupt) |=> unitLed == optionLed)
		else $error("fw update phase");
	a_opt_dark: assert property (@(posedge sys_clk) disable iff (!resetn)
		(!optPresent && !fwUpdate) |=> optionLed == `SLI_LED_OFF)
		else $error("option lit");
	a_opt_green: assert property (@(posedge sys_clk) disable iff (!resetn)
		(optPresent && optObject && optReady && !optFault && !optSpecial
		&& !fwUpdate) |=> optionLed == `SLI_LED_GREEN)
		else $error("option not green");
	a_fb_slow_green: assert property (@(posedge sys_clk)
		disable iff (!resetn) (dataExchange && !cyclicOk && seenCyclic_reg
		&& !commInterrupt && !cfgFault && !lostExchange && !baudSearch
		&& !noLink && !serialSel) |=> fieldbusLed
		== ($past(slowPhase) ? `SLI_LED_GREEN : `SLI_LED_OFF))
		else $error("fieldbus green flash");
	a_fb_serial_slow: assert property (@(posedge sys_clk)
		disable iff (!resetn) (serialSel && serialActive && !procDataRx
		&& !commInterrupt && !cfgFault && !lostExchange && !baudSearch
		&& !noLink) |=> fieldbusLed
		== ($past(slowPhase) ? `SLI_LED_RED : `SLI_LED_OFF))
		else $error("serial red flash");
	a_opt_special: assert property (@(posedge sys_clk)
		disable iff (!resetn) (optPresent && optObject && optReady
		&& !optFault && optSpecial && !fwUpdate) |=> optionLed
		== ($past(slowPhase) ? `SLI_LED_GREEN : `SLI_LED_OFF))
		else $error("option green flash");
	a_opt_fault: assert property (@(posedge sys_clk)
		disable iff (!resetn) (optPresent && optObject
		&& (optFault || !optReady) && !fwUpdate) |=> optionLed
		== ($past(fastPhase) ? `SLI_LED_RED : `SLI_LED_OFF))
		else $error("option red flash");
	a_intr_red: assert property (@(posedge sys_clk) disable iff (!resetn)
		commInterrupt |=> unitLed
		== ($past(fastPhase) ? `SLI_LED_RED : `SLI_LED_OFF))
		else $error("unit red flash");
	a_fw_flash: assert property (@(posedge sys_clk) disable iff (!resetn)
		(fwUpdate && !commInterrupt) |=> unitLed
		== ($past(slowPhase) ? `SLI_LED_ORANGE : `SLI_LED_OFF))
		else $error("unit orange flash");
	// slow edges must coincide with fast edges or flashes drift apart
	a_phase_nest: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(slowPhase) |-> $rose(fastPhase))
		else $error("phases apart");
	a_seen_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
		seenCyclic_reg |=> seenCyclic_reg)
		else $error("first cyclic lost");
endmodule
`default_nettype wire

// File: dv/tb_status_led_indicator_encoder.sv
// self-checking bench for the status indicator encoder
`timescale 1ns/10ps
`default_nettype none
`include "sli_params.svh"
module tb_status_led_indicator_encoder;
	import sli_pkg::*;
	localparam logic [1:0] STEADY = 2'h0;
	localparam logic [1:0] SLOW = 2'h1;
	localparam logic [1:0] FAST = 2'h2;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic [1:0] unitLed, fieldbusLed, optionLed, spareLed;
	logic [3:0] obs [4];
	logic [31:0] rdat;
	int failures = 0;
	int checks = 0;
	int diffUf, diffUo;

	// short tick keeps one slow flash period at 64 cycles
	sli_led_encoder #(.TICK_CYCLES(4)) dut (.sys_clk(sys_clk),
		.resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.unitLed(unitLed), .fieldbusLed(fieldbusLed),
		.optionLed(optionLed), .spareLed(spareLed));

	always #5 sys_clk = ~sys_clk;

	task results;
		if (failures == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// the only bounded wait: a stuck hready ends the run
	task waitReady;
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1) begin
			failures++;
			results();
		end
	endtask

	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		waitReady;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		waitReady;
		rdat = hrdata;
		chk(hresp, 1'b0);
	endtask

	// classifies each indicator over 128 cycles: steady, slow or fast
	task observe;
		logic [1:0] cur [4];
		logic [1:0] prev [4];
		logic [1:0] col [4];
		int tr [4];
		repeat (4) @(posedge sys_clk);
		#1;
		prev = '{unitLed, fieldbusLed, optionLed, spareLed};
		diffUf = 0;
		diffUo = 0;
		for (int i = 0; i < 4; i++) begin
			tr[i] = 0;
			col[i] = prev[i];
		end
		repeat (128) begin
			@(posedge sys_clk);
			#1;
			cur = '{unitLed, fieldbusLed, optionLed, spareLed};
			if (unitLed !== fieldbusLed) diffUf++;
			if (unitLed !== optionLed) diffUo++;
			for (int i = 0; i < 4; i++) begin
				if (cur[i] !== prev[i]) tr[i]++;
				col[i] = col[i] | cur[i];
			end
			prev = cur;
		end
		for (int i = 0; i < 4; i++)
			obs[i] = {tr[i] == 0 ? STEADY : tr[i] <= 5 ? SLOW :
				tr[i] >= 12 ? FAST : 2'h3, col[i]};
	endtask

	task setState(input logic [15:0] c, input logic [7:0] o);
		ahb(1'b1, `SLI_ADDR_CTRL, {16'h0, c});
		ahb(1'b1, `SLI_ADDR_OPT, {24'h0, o});
		observe;
	endtask

	task expLeds(input logic [3:0] u, input logic [3:0] f, input logic [3:0] o);
		chk(obs[0], u);
		chk(obs[1], f);
		chk(obs[2], o);
		chk(obs[3], 4'h0);
	endtask

	task tDarkStart;
		observe;
		expLeds(4'h0, 4'h0, 4'h0);
		ahb(1'b0, `SLI_ADDR_CTRL, 32'h0);
		chk(rdat, 32'h0);
		setState(16'h0002, 8'h00);
		expLeds(4'h0, 4'h0, 4'h0);
	endtask

	task tFieldbus;
		setState(16'h0401, 8'h00);
		expLeds({STEADY, SLI_GREEN}, {STEADY, SLI_GREEN}, 4'h0);
		ahb(1'b1, 32'h0000_0010, 32'hffff_ffff);
		ahb(1'b0, 32'h0000_0010, 32'h0);
		chk(rdat, 32'h0);
		ahb(1'b0, `SLI_ADDR_CTRL, 32'h0);
		chk(rdat, 32'h0401);
		ahb(1'b0, `SLI_ADDR_STAT, 32'h0);
		chk(rdat & 32'h0000_01ff, 32'h0000_0105);
		setState(16'h0002, 8'h00);
		chk(obs[1], {SLOW, SLI_GREEN});
		setState(16'h0004, 8'h00);
		chk(obs[1], {STEADY, SLI_RED});
		setState(16'h000c, 8'h00);
		chk(obs[1], {SLOW, SLI_RED});
		for (int i = 5; i <= 8; i++) begin
			setState(16'(1 << i), 8'h00);
			expLeds(4'h0, {FAST, SLI_RED}, 4'h0);
		end
	endtask

	task tInterrupt;
		setState(16'h0601, 8'h07);
		expLeds({FAST, SLI_RED}, {FAST, SLI_RED}, {STEADY, SLI_GREEN});
		chk(diffUf, 0);
	endtask

	task tFirmware;
		setState(16'h1401, 8'h07);
		expLeds({SLOW, SLI_ORANGE}, {STEADY, SLI_GREEN}, {SLOW, SLI_ORANGE});
		chk(diffUo, 0);
	endtask

	// absent, no drive object, not ready, ready, special, fault
	task tOption;
		logic [7:0] optIn [7];
		logic [3:0] optExp [7];
		optIn = '{8'h00, 8'h06, 8'h03, 8'h05, 8'h07, 8'h0f, 8'h17};
		optExp = '{4'h0, 4'h0, 4'h0, {FAST, SLI_RED}, {STEADY, SLI_GREEN},
			{SLOW, SLI_GREEN}, {FAST, SLI_RED}};
		for (int i = 0; i < 7; i++) begin
			setState(16'h0401, optIn[i]);
			chk(obs[2], optExp[i]);
		end
	endtask

	initial begin
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		tDarkStart;
		tFieldbus;
		tOption;
		tInterrupt;
		tFirmware;
		results();
	end
endmodule
`default_nettype wire
